// [rtl/timer_channel_capture_compare.v]
// two-channel capture/compare/pwm timer channel logic with an axi4-lite register slave
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "timer_channel_map.vh"

module timer_channel_capture_compare (
    input  wire        core_clk,       // block clock, 125 mhz
    input  wire        sys_rst,        // synchronous reset, active high
    input  wire        clk_en,         // freezes all state while low
    input  wire        timer_tick,     // prescaled counter advance strobe
    input  wire        break_active,   // debug break in progress
    input  wire [1:0]  pin_in,         // channel pin levels, asynchronous
    output reg  [1:0]  pin_out,        // channel pin drive level
    output reg  [1:0]  pin_oe,         // channel pin output enable
    output reg  [1:0]  channel_irq,    // per-channel interrupt request
    input  wire [7:0]  s_axi_awaddr,   // write address
    input  wire        s_axi_awvalid,  // write address valid
    output reg         s_axi_awready,  // write address ready
    input  wire [31:0] s_axi_wdata,    // write data
    input  wire [3:0]  s_axi_wstrb,    // write byte strobes
    input  wire        s_axi_wvalid,   // write data valid
    output reg         s_axi_wready,   // write data ready
    output reg  [1:0]  s_axi_bresp,    // write response
    output reg         s_axi_bvalid,   // write response valid
    input  wire        s_axi_bready,   // write response ready
    input  wire [7:0]  s_axi_araddr,   // read address
    input  wire        s_axi_arvalid,  // read address valid
    output reg         s_axi_arready,  // read address ready
    output reg  [31:0] s_axi_rdata,    // read data
    output reg  [1:0]  s_axi_rresp,    // read response
    output reg         s_axi_rvalid,   // read data valid
    input  wire        s_axi_rready    // read data ready
);

    reg  [6:0]  ctl_reg [0:1];      // channel control bits below the flag
    reg  [15:0] val_reg [0:1];      // channel value pairs
    reg  [1:0]  flag_reg;           // channel event flags
    reg  [1:0]  arm_reg;            // flag read while set, clear armed
    reg  [1:0]  cap_block_reg;      // capture held after high byte read
    reg  [1:0]  cmp_block_reg;      // compare held after high byte write
    reg  [1:0]  max_eff_reg;        // max-duty in force this pwm cycle
    reg  [1:0]  sync1_reg;          // pin synchroniser first stage
    reg  [1:0]  sync2_reg;          // pin synchroniser second stage
    reg  [1:0]  prev_reg;           // previous synchronised level
    reg  [15:0] counter_reg;        // shared timer counter
    reg  [15:0] modulo_reg;         // counter modulo value
    reg         stop_reg;           // counter stopped
    reg         ovf_flag_reg;       // overflow seen
    reg         buf_sel_reg;        // pair in use in buffered mode
    reg         buf_pend_reg;       // pair to use from next overflow
    reg  [7:0]  awaddr_reg;         // held write address
    reg  [31:0] wdata_reg;          // held write data
    reg  [3:0]  wstrb_reg;          // held write strobes
    reg  [7:0]  araddr_reg;         // held read address

    reg  [1:0]  cap_mode;
    reg  [1:0]  cmp_mode;
    reg  [1:0]  cap_hit;
    reg  [1:0]  cmp_hit;
    reg  [1:0]  ch_on;
    reg  [1:0]  els_t;
    reg  [15:0] cmp_val;
    reg         blk_t;
    reg  [31:0] rd_mux;
    integer     i;

    wire        buffered  = ctl_reg[0][`MSB_BIT];
    wire        wr_fire   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    wire        rd_fire   = ~s_axi_arready & ~s_axi_rvalid;
    wire [3:0]  widx      = reg_index(awaddr_reg);
    wire [3:0]  ridx      = reg_index(araddr_reg);
    wire        wr_lane   = wr_fire & wstrb_reg[0];
    wire        count_run = timer_tick & ~stop_reg & ~break_active;
    wire        ovf       = count_run & (counter_reg == modulo_reg);

    // map a byte address to a register index, or the bad index
    function [3:0] reg_index;
        input [7:0] a;
        begin
            if (a[1:0] != 2'b00 || a[7:6] != 2'b00 || a[5:2] > `LAST_IDX)
                reg_index = `BAD_IDX;
            else
                reg_index = a[5:2];
        end
    endfunction

    // active edge test for a capture channel
    function edge_hit;
        input [1:0] els;
        input       now;
        input       was;
        begin
            case (els)
                `ELS_TOGGLE: edge_hit = now & ~was;
                `ELS_CLEAR:  edge_hit = ~now & was;
                `ELS_SET:    edge_hit = now ^ was;
                default:     edge_hit = 1'b0;
            endcase
        end
    endfunction

    // pin level after a compare action
    function pin_action;
        input [1:0] els;
        input       cur;
        begin
            case (els)
                `ELS_TOGGLE: pin_action = ~cur;
                `ELS_CLEAR:  pin_action = 1'b0;
                `ELS_SET:    pin_action = 1'b1;
                default:     pin_action = cur;
            endcase
        end
    endfunction

    // per-channel mode decode and event detection
    always @* begin
        cap_mode = 2'b00;
        cmp_mode = 2'b00;
        cap_hit  = 2'b00;
        cmp_hit  = 2'b00;
        ch_on    = 2'b00;
        els_t    = 2'b00;
        cmp_val  = 16'h0000;
        blk_t    = 1'b0;
        for (i = 0; i < 2; i = i + 1) begin
            els_t = ctl_reg[i][`ELSB_BIT:`ELSA_BIT];
            // channel 1 off in buffered mode
            ch_on[i] = ~((i == 1) & buffered);
            cap_mode[i] = ch_on[i] & ~((i == 0) & buffered) & ~ctl_reg[i][`MSA_BIT] & (els_t != `ELS_NONE);
            cmp_mode[i] = ch_on[i] & (((i == 0) & buffered) | ctl_reg[i][`MSA_BIT]);
            if ((i == 0) & buffered) begin
                cmp_val = val_reg[buf_sel_reg];
                blk_t   = cmp_block_reg[0] | cmp_block_reg[1];
            end else begin
                cmp_val = val_reg[i];
                blk_t   = cmp_block_reg[i];
            end
            cmp_hit[i] = cmp_mode[i] & count_run & (counter_reg == cmp_val) & ~blk_t;
            cap_hit[i] = cap_mode[i] & ~stop_reg & ~cap_block_reg[i] & edge_hit(els_t, sync2_reg[i], prev_reg[i]);
        end
    end

    // read data multiplexer
    always @* begin
        rd_mux = 32'h00000000;
        case (ridx)
            `CH0_CTRL_IDX:   rd_mux = {24'h000000, flag_reg[0], ctl_reg[0]};
            `CH1_CTRL_IDX:   rd_mux = buffered ? 32'h00000000 : {24'h000000, flag_reg[1], ctl_reg[1]};
            `CH0_HIGH_IDX:   rd_mux = {24'h000000, val_reg[0][15:8]};
            `CH0_LOW_IDX:    rd_mux = {24'h000000, val_reg[0][7:0]};
            `CH1_HIGH_IDX:   rd_mux = {24'h000000, val_reg[1][15:8]};
            `CH1_LOW_IDX:    rd_mux = {24'h000000, val_reg[1][7:0]};
            `TIMER_CTRL_IDX: rd_mux = {24'h000000, ovf_flag_reg, 6'h00, stop_reg};
            `MODULO_IDX:     rd_mux = {16'h0000, modulo_reg};
            `COUNTER_IDX:    rd_mux = {16'h0000, counter_reg};
            default:         rd_mux = 32'h00000000;
        endcase
    end

    // axi4-lite handshakes: take address and data in either order, answer after both
    always @(posedge core_clk) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `RESP_OKAY;
            s_axi_rdata   <= 32'h00000000;
            awaddr_reg    <= 8'h00;
            wdata_reg     <= 32'h00000000;
            wstrb_reg     <= 4'h0;
            araddr_reg    <= 8'h00;
        end else if (clk_en) begin
            if (s_axi_awready & s_axi_awvalid) begin
                awaddr_reg    <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wready & s_axi_wvalid) begin
                wdata_reg    <= s_axi_wdata;
                wstrb_reg    <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (widx == `BAD_IDX) ? `RESP_SLVERR : `RESP_OKAY;
            end
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (s_axi_arready & s_axi_arvalid) begin
                araddr_reg    <= s_axi_araddr;
                s_axi_arready <= 1'b0;
            end
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= (ridx == `BAD_IDX) ? `RESP_SLVERR : `RESP_OKAY;
            end
            if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // shared counter, modulo, stop and overflow flag
    always @(posedge core_clk) begin
        if (sys_rst) begin
            counter_reg  <= 16'h0000;
            modulo_reg   <= `MODULO_RESET;
            stop_reg     <= `STOP_RESET;
            ovf_flag_reg <= 1'b0;
            buf_sel_reg  <= 1'b0;
            sync1_reg    <= 2'b00;
            sync2_reg    <= 2'b00;
            prev_reg     <= 2'b00;
        end else if (clk_en) begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
            if (wr_lane & (widx == `TIMER_CTRL_IDX) & wdata_reg[`RESET_BIT])
                counter_reg <= 16'h0000;
            else if (ovf)
                counter_reg <= 16'h0000;
            else if (count_run)
                counter_reg <= counter_reg + 16'h0001;
            if (wr_lane & (widx == `TIMER_CTRL_IDX))
                stop_reg <= wdata_reg[`STOP_BIT];
            if (wr_fire & (widx == `MODULO_IDX)) begin
                if (wstrb_reg[0])
                    modulo_reg[7:0] <= wdata_reg[7:0];
                if (wstrb_reg[1])
                    modulo_reg[15:8] <= wdata_reg[15:8];
            end
            // overflow sets win over a software clear
            if (ovf)
                ovf_flag_reg <= 1'b1;
            else if (wr_lane & (widx == `TIMER_CTRL_IDX) & ~wdata_reg[`OVF_BIT])
                ovf_flag_reg <= 1'b0;
            // pending pair becomes active at overflow
            if (ovf)
                buf_sel_reg <= buf_pend_reg;
        end
    end

    // channel control, flags, value pairs and pin drive
    always @(posedge core_clk) begin
        if (sys_rst) begin
            flag_reg      <= 2'b00;
            arm_reg       <= 2'b00;
            cap_block_reg <= 2'b00;
            cmp_block_reg <= 2'b00;
            max_eff_reg   <= 2'b00;
            pin_out       <= 2'b00;
            pin_oe        <= 2'b00;
            channel_irq   <= 2'b00;
            buf_pend_reg  <= 1'b0;
            for (i = 0; i < 2; i = i + 1) begin
                // control bits, buffered select among them, clear at reset
                ctl_reg[i] <= `CTRL_RESET;
                val_reg[i] <= 16'h0000;
            end
        end else if (clk_en) begin
            for (i = 0; i < 2; i = i + 1) begin
                // event sets win over the armed clear
                if (cmp_hit[i] | cap_hit[i])
                    flag_reg[i] <= 1'b1;
                else if (wr_lane & (widx == `CH0_CTRL_IDX + i) & ch_on[i] & ~wdata_reg[`FLAG_BIT] & arm_reg[i])
                    flag_reg[i] <= 1'b0;
                if (cmp_hit[i] | cap_hit[i])
                    arm_reg[i] <= 1'b0;
                else if (rd_fire & (ridx == `CH0_CTRL_IDX + i) & ch_on[i] & flag_reg[i])
                    arm_reg[i] <= 1'b1;
                else if (wr_lane & (widx == `CH0_CTRL_IDX + i))
                    arm_reg[i] <= 1'b0;
                // channel 1 control ignores writes in buffered mode
                if (wr_lane & (widx == `CH0_CTRL_IDX + i) & ch_on[i]) begin
                    ctl_reg[i] <= wdata_reg[6:0];
                    // buffered select only in channel 0
                    if (i == 1)
                        ctl_reg[i][`MSB_BIT] <= 1'b0;
                end
                // value pair written a byte at a time
                if (wr_lane & (widx == `CH0_HIGH_IDX + 2 * i)) begin
                    val_reg[i][15:8] <= wdata_reg[7:0];
                    cmp_block_reg[i] <= cmp_mode[i] | ((i == 1) & buffered);
                end
                if (wr_lane & (widx == `CH0_LOW_IDX + 2 * i)) begin
                    val_reg[i][7:0]  <= wdata_reg[7:0];
                    cmp_block_reg[i] <= 1'b0;
                    if (buffered)
                        buf_pend_reg <= (i == 1);
                end
                // capture copies counter with the flag
                if (cap_hit[i])
                    val_reg[i] <= counter_reg;
                // high read holds captures until low read
                if (rd_fire & (ridx == `CH0_HIGH_IDX + 2 * i) & cap_mode[i])
                    cap_block_reg[i] <= 1'b1;
                else if (rd_fire & (ridx == `CH0_LOW_IDX + 2 * i))
                    cap_block_reg[i] <= 1'b0;
                if (ovf)
                    max_eff_reg[i] <= ctl_reg[i][`MAX_BIT];
                channel_irq[i] <= flag_reg[i] & ctl_reg[i][`IE_BIT] & ch_on[i];
                if (~ch_on[i] | (ctl_reg[i][`ELSB_BIT:`ELSA_BIT] == `ELS_NONE)) begin
                    pin_oe[i] <= 1'b0;
                    pin_out[i] <= ~ctl_reg[i][`MSA_BIT];
                end else if (~cmp_mode[i]) begin
                    pin_oe[i] <= 1'b0;
                end else begin
                    pin_oe[i] <= 1'b1;
                    if (ovf & ctl_reg[i][`TOV_BIT]) begin
                        // forced full duty holds the active level
                        if (ctl_reg[i][`MAX_BIT])
                            pin_out[i] <= (ctl_reg[i][`ELSB_BIT:`ELSA_BIT] != `ELS_SET);
                        else
                            pin_out[i] <= ~pin_out[i];
                    end else if (cmp_hit[i] & ~(max_eff_reg[i] & ctl_reg[i][`TOV_BIT])) begin
                        pin_out[i] <= pin_action(ctl_reg[i][`ELSB_BIT:`ELSA_BIT], pin_out[i]);
                    end
                end
            end
        end
    end

endmodule // timer_channel_capture_compare

// [rtl/timer_channel_map.vh]
// register indices, field positions and reset values of the two-channel capture/compare block
`ifndef TIMER_CHANNEL_MAP_VH
`define TIMER_CHANNEL_MAP_VH

// register indices; byte address is four times the index
`define CH0_CTRL_IDX     4'h0
`define CH1_CTRL_IDX     4'h1
`define CH0_HIGH_IDX     4'h2
`define CH0_LOW_IDX      4'h3
`define CH1_HIGH_IDX     4'h4
`define CH1_LOW_IDX      4'h5
`define TIMER_CTRL_IDX   4'h6
`define MODULO_IDX       4'h7
`define COUNTER_IDX      4'h8
`define LAST_IDX         4'h8
`define BAD_IDX          4'hf

// channel control/status fields
`define FLAG_BIT         7
`define IE_BIT           6
`define MSB_BIT          5
`define MSA_BIT          4
`define ELSB_BIT         3
`define ELSA_BIT         2
`define TOV_BIT          1
`define MAX_BIT          0

// timer control fields
`define STOP_BIT         0
`define RESET_BIT        1
`define OVF_BIT          7

// edge/level codes
`define ELS_NONE         2'b00
`define ELS_TOGGLE       2'b01
`define ELS_CLEAR        2'b10
`define ELS_SET          2'b11

// reset values
`define CTRL_RESET       7'h00
`define MODULO_RESET     16'hffff
`define STOP_RESET       1'b1

// bus answers
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// [dv/pin_partner.sv]
// far-side pin model: outside sources on the two channel pins
`timescale 1ns/100ps
module pin_partner (
    input  wire [1:0] ext_level,  // level the outside source drives
    input  wire [1:0] pin_out,    // block drive level
    input  wire [1:0] pin_oe,     // block drive enable
    output wire [1:0] pin_line    // resolved pin level
);
    // block wins where it drives, else the source; edges land 2 ns late
    assign #2 pin_line = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // pin_partner

// [dv/timer_channel_capture_compare_monitor.sv]
// concurrent checks on the capture/compare block ports
`timescale 1ns/100ps
module timer_channel_capture_compare_monitor (
    input wire        core_clk,       // clock
    input wire        sys_rst,        // sync reset
    input wire [1:0]  pin_oe,         // pin enables
    input wire [1:0]  channel_irq,    // requests
    input wire [7:0]  s_axi_awaddr,   // write address
    input wire        s_axi_awvalid,  // aw valid
    input wire        s_axi_awready,  // aw ready
    input wire        s_axi_wvalid,   // w valid
    input wire        s_axi_wready,   // w ready
    input wire [1:0]  s_axi_bresp,    // write answer
    input wire        s_axi_bvalid,   // b valid
    input wire        s_axi_bready,   // b ready
    input wire [7:0]  s_axi_araddr,   // read address
    input wire        s_axi_arvalid,  // ar valid
    input wire        s_axi_arready,  // ar ready
    input wire [31:0] s_axi_rdata,    // read data
    input wire [1:0]  s_axi_rresp,    // read answer
    input wire        s_axi_rvalid,   // r valid
    input wire        s_axi_rready    // r ready
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire rd_go = s_axi_arvalid && s_axi_arready;
    a_reset_quiet: assert property ($fell(sys_rst) |-> pin_oe == 2'b00 && channel_irq == 2'b00
        && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs active after reset");
    a_write_answer: assert property (wr_go |=> !s_axi_awready ##1 s_axi_bvalid)
        else $error("write answer late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_read_answer: assert property (rd_go |=> !s_axi_arready ##1 s_axi_rvalid)
        else $error("read answer late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_bad_write: assert property (wr_go && s_axi_awaddr > 8'h23 |-> ##2 s_axi_bresp == 2'b10)
        else $error("unmapped write not refused");
    a_bad_read: assert property (rd_go && s_axi_araddr > 8'h23 |-> ##2 s_axi_rresp == 2'b10
        && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
    a_wready_busy: assert property (wr_go |=> !s_axi_wready [*1] ##1 !s_axi_wready)
        else $error("write taken while busy");
endmodule // timer_channel_capture_compare_monitor

// [dv/tb_timer_channel_capture_compare.sv]
// self-checking bench for the capture/compare block
`timescale 1ns/100ps
`include "timer_channel_map.vh"
module tb_timer_channel_capture_compare;
    reg         core_clk, sys_rst, timer_tick, break_active;
    reg  [1:0]  lvl;
    reg  [7:0]  aw_addr, ar_addr;
    reg  [31:0] w_data, rv, cnt, h;
    reg         aw_valid, w_valid, b_ready, ar_valid, r_ready, ex;
    reg  [1:0]  rsp;
    wire [1:0]  pin_in, pin_out, pin_oe, channel_irq, bresp, rresp;
    wire        awready, wready, bvalid, arready, rvalid;
    wire [31:0] rdata;
    integer     num_errors, n_compared, cyc, i, c, e, k;
    reg  [15:0] v;
    pin_partner PIN (.ext_level(lvl), .pin_out(pin_out), .pin_oe(pin_oe), .pin_line(pin_in));
    timer_channel_capture_compare DUT (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1),
        .timer_tick(timer_tick), .break_active(break_active), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .channel_irq(channel_irq), .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid),
        .s_axi_awready(awready), .s_axi_wdata(w_data), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_valid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(b_ready),
        .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(r_ready));
    // clock, 8 ns period
    initial begin
        core_clk = 0;
        forever #4 core_clk = ~core_clk;
    end
    // hang guard
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            print_verdict;
        end
    end
    task chk(input [255:0] nm, input [31:0] seen, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // one register write, address and data offered together
    task wr(input [3:0] x, input [31:0] d);
        reg a_ok, w_ok;
        begin
            a_ok = 0;
            w_ok = 0;
            @(posedge core_clk);
            aw_addr <= {2'b00, x, 2'b00};
            w_data <= d;
            aw_valid <= 1;
            w_valid <= 1;
            b_ready <= 1;
            while (!(a_ok && w_ok)) begin
                @(posedge core_clk);
                if (aw_valid && awready) begin
                    a_ok = 1;
                    aw_valid <= 0;
                end
                if (w_valid && wready) begin
                    w_ok = 1;
                    w_valid <= 0;
                end
            end
            do @(posedge core_clk); while (!bvalid);
            rsp = bresp;
            b_ready <= 0;
        end
    endtask
    // one register read
    task rd(input [3:0] x);
        begin
            @(posedge core_clk);
            ar_addr <= {2'b00, x, 2'b00};
            ar_valid <= 1;
            r_ready <= 1;
            do @(posedge core_clk); while (!arready);
            ar_valid <= 0;
            do @(posedge core_clk); while (!rvalid);
            rv = rdata;
            rsp = rresp;
            r_ready <= 0;
        end
    endtask
    function [31:0] rst_exp(input integer x);
        rst_exp = (x == 6) ? 32'h1 : (x == 7) ? 32'hffff : 32'h0;
    endfunction
    task print_verdict;
        begin
            $display("compared %0d mismatches %0d", n_compared, num_errors);
            if (num_errors == 0 && n_compared > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task toggle_pin(input exp);
        begin
            lvl[1] <= ~lvl[1];
            repeat (8) @(posedge core_clk);
            chk("capture flag", channel_irq[1], exp);
        end
    endtask
    // main sequence
    initial begin
        {num_errors, n_compared, cyc} = 0;
        {sys_rst, timer_tick, break_active, lvl} = 5'b10100;
        {aw_valid, w_valid, b_ready, ar_valid, r_ready} = 0;
        {aw_addr, ar_addr, w_data} = 0;
        rv = $urandom(32'h3f12);
        repeat (4) @(posedge core_clk);
        sys_rst <= 0;
        for (i = 0; i < 9; i = i + 1) begin
            rd(i);
            chk("reset value", rv, rst_exp(i));
        end
        chk("preset pins", {pin_oe, pin_out}, 4'b0011);
        rd(`BAD_IDX);
        chk("bad read", rsp, `RESP_SLVERR);
        wr(`BAD_IDX, 32'h5);
        chk("bad write", rsp, `RESP_SLVERR);
        wr(`CH0_CTRL_IDX, 32'h10);
        // pin drive follows the control write by one clock
        @(posedge core_clk);
        chk("preset low", pin_out[0], 1'b0);
        $display("register test done");
        // counter runs at random, then freezes under break
        wr(`TIMER_CTRL_IDX, 32'h0);
        break_active <= 0;
        repeat ($urandom_range(200, 50)) @(posedge core_clk) timer_tick <= $urandom;
        break_active <= 1;
        for (c = 1; c < 4; c = c + 1) begin
            wr(`CH1_CTRL_IDX, 32'h40 | c << 2);
            rd(`CH1_CTRL_IDX);
            wr(`CH1_CTRL_IDX, 32'h40 | c << 2);
            rd(`COUNTER_IDX);
            cnt = rv;
            for (e = 0; e < 2; e = e + 1) begin
                ex = c == 3 || c == e + 1;
                toggle_pin(ex);
                if (ex) begin
                    rd(`CH1_HIGH_IDX);
                    h = rv;
                    rd(`CH1_LOW_IDX);
                    chk("captured", {h[7:0], rv[7:0]}, cnt[15:0]);
                end
                rd(`CH1_CTRL_IDX);
                wr(`CH1_CTRL_IDX, 32'h40 | c << 2);
            end
        end
        rd(`CH1_HIGH_IDX);
        toggle_pin(1'b0);
        rd(`CH1_LOW_IDX);
        toggle_pin(1'b1);
        $display("capture test done");
        // overflow against clear, then compare set, clear, toggle
        for (c = 4; c > 0; c = c - 1) begin
            v = (c == 4) ? 16'h20 : $urandom_range(80, 16);
            // stop and reset the counter before changing mode bits
            wr(`TIMER_CTRL_IDX, 32'h3);
            wr(`MODULO_IDX, (c == 4) ? 32'h20 : 32'hffff);
            wr(`CH0_CTRL_IDX, (c == 4) ? 32'h5a : 32'h50 | c << 2);
            wr(`CH0_HIGH_IDX, v[15:8]);
            wr(`CH0_LOW_IDX, v[7:0]);
            rd(`CH0_CTRL_IDX);
            wr(`CH0_CTRL_IDX, (c == 4) ? 32'h5a : 32'h50 | c << 2);
            wr(`TIMER_CTRL_IDX, 32'h0);
            timer_tick <= 1;
            break_active <= 0;
            k = 0;
            while (!channel_irq[0] && k < 300) begin
                @(posedge core_clk);
                k = k + 1;
            end
            break_active <= 1;
            // overflow toggle from low beats the clear action in the first pass
            chk("compare pin", {pin_oe[0], pin_out[0]}, {1'b1, c != 2});
        end
        $display("compare test done");
        wr(`CH0_CTRL_IDX, 32'h24);
        wr(`CH1_CTRL_IDX, 32'h44);
        rd(`CH1_CTRL_IDX);
        chk("ch1 disabled", {rv[30:0], pin_oe[1]}, 32'h0);
        $display("buffered test done");
        print_verdict;
    end
endmodule // tb_timer_channel_capture_compare

bind timer_channel_capture_compare timer_channel_capture_compare_monitor MON (
    .core_clk(core_clk), .sys_rst(sys_rst), .pin_oe(pin_oe), .channel_irq(channel_irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
